//--- rtl/dmc_ctrl.sv
// two-port dynamic memory controller with refresh and programmed mode bits
//
// Overview of operation
// - row timing code low-then-high: row strobe low two host clocks, precharge two.
// - wait timing zero: ready follows the row strobe falling, no added clocks.
// - burst wait bits zero: burst accesses get no added wait states.
// - extension bit low and wait-insert input low adds one host clock.
// - divider code turns the delay-line clock into about 2 MHz; 101 divides by five.
// - bank config 011 decodes both bank selects to one row strobe; byte writes.
// - column-setup bit high: column address with zero setup before column strobe.
// - row-hold bit high: row address held 15 ns after row strobe falls.
// - write-delay bit high: write column strobe one host clock after row strobe.
// - column extend low: column strobes end together with the row strobe.
// - normal accesses take zero or more waits set by the wait timing bits.
// - arbitrate between port A, port B and refresh, one at a time.
// - withhold ready during precharge, refresh or the other port's access.
// - zero-wait read completes within two host clocks, 200 ns.
`timescale 1ns/100ps
module dmc_ctrl #(
    parameter int ADDR_W        = 10,
    parameter int REFRESH_TICKS = dmc_pkg::REFRESH_TICKS
) (
    input  wire logic              i_clk_sys,
    input  wire logic              i_rst,
    input  wire logic              i_delay_line_clock_input,
    input  wire logic              i_prog,
    input  wire logic              i_row_timing_bit_low,
    input  wire logic              i_row_timing_bit_high,
    input  wire logic              i_wait_timing_bit_a,
    input  wire logic              i_wait_timing_bit_b,
    input  wire logic              i_burst_wait_bit_a,
    input  wire logic              i_burst_wait_bit_b,
    input  wire logic              i_wait_extension_bit,
    input  wire logic [2:0]        i_div_sel,
    input  wire logic              i_bank_config_bit_a,
    input  wire logic              i_bank_config_bit_b,
    input  wire logic              i_bank_config_bit_c,
    input  wire logic              i_column_setup_bit,
    input  wire logic              i_row_hold_bit,
    input  wire logic              i_write_delay_bit,
    input  wire logic              i_column_extend_control,
    input  wire logic              i_wait_insert_input,
    input  wire logic [1:0]        i_req,
    input  wire logic [1:0]        i_write_request_input,
    input  wire logic [1:0]        i_burst,
    input  wire logic [3:0]        i_bank_select_inputs,
    input  wire logic [3:0]        i_byte_lane,
    input  wire logic [2*ADDR_W-1:0] i_row_addr,
    input  wire logic [2*ADDR_W-1:0] i_col_addr,
    output logic [3:0]             o_ras_n,
    output logic [1:0]             o_cas_n,
    output logic                   o_we_n,
    output logic [ADDR_W-1:0]      o_addr,
    output logic [1:0]             o_ready,
    output logic                   o_grant_b,
    output logic                   o_refresh_busy
);
    // ==========================================================
    // elaboration checks
    if (ADDR_W < 1 || REFRESH_TICKS < 1 || REFRESH_TICKS > 255) begin : g_bad_param
        $error("dmc_ctrl: unsupported parameter value");
    end
    if (dmc_pkg::RAS_LOW_CYC > dmc_pkg::READ_MAX_CYC) begin : g_bad_timing
        $error("dmc_ctrl: row strobe too long for zero-wait read");
    end

    localparam int CW = dmc_pkg::CNT_W;

    // ==========================================================
    // mode capture and refresh tick
    dmc_pkg::dmc_mode_t  mode;
    dmc_pkg::dmc_mode_t  next_mode;
    dmc_tick_if          tk ();

    dmc_tick_div u_div (
        .i_clk_sys                (i_clk_sys),
        .i_rst                    (i_rst),
        .i_delay_line_clock_input (i_delay_line_clock_input),
        .tk                       (tk.gen)
    );
    assign tk.div_sel = mode.div_sel;

    always_comb begin
        next_mode = mode;
        if (i_prog) begin
            next_mode.row_timing  = {i_row_timing_bit_high, i_row_timing_bit_low};
            next_mode.wait_timing = {i_wait_timing_bit_b, i_wait_timing_bit_a};
            next_mode.burst_wait  = {i_burst_wait_bit_b, i_burst_wait_bit_a};
            next_mode.wait_ext    = i_wait_extension_bit;
            next_mode.div_sel     = i_div_sel;
            next_mode.bank_cfg    = {i_bank_config_bit_c, i_bank_config_bit_b,
                                     i_bank_config_bit_a};
            next_mode.col_setup   = i_column_setup_bit;
            next_mode.row_hold    = i_row_hold_bit;
            next_mode.write_delay = i_write_delay_bit;
            next_mode.col_extend  = i_column_extend_control;
        end
    end

    // ==========================================================
    // access sequencer state
    dmc_pkg::dmc_state_t  state;
    dmc_pkg::dmc_state_t  next_state;
    dmc_pkg::dmc_owner_t  owner;
    dmc_pkg::dmc_owner_t  next_owner;
    logic [CW-1:0]        cnt;
    logic [CW-1:0]        next_cnt;
    logic [CW-1:0]        extra;
    logic [CW-1:0]        next_extra;
    logic [7:0]           ref_cnt;
    logic [7:0]           next_ref_cnt;
    logic                 ref_pend;
    logic                 next_ref_pend;
    logic                 last_b;
    logic                 next_last_b;
    logic                 wr;
    logic                 next_wr;
    logic [1:0]           lane;
    logic [1:0]           next_lane;
    logic [ADDR_W-1:0]    col;
    logic [ADDR_W-1:0]    next_col;
    logic [3:0]           next_ras_n;
    logic [1:0]           next_cas_n;
    logic                 next_we_n;
    logic [ADDR_W-1:0]    next_addr;
    logic [1:0]           next_ready;
    logic                 next_grant_b;
    logic                 next_refresh_busy;

    // timing points inside an access
    logic [CW-1:0]        col_at;
    logic [CW-1:0]        cas_at;
    logic [CW-1:0]        low_cnt;
    logic [CW-1:0]        pre_cnt;
    logic                 pick_b;
    logic [1:0]           wcode;
    logic [1:0]           bank;
    logic                 is_ref;

    always_comb begin
        col_at = CW'(dmc_pkg::ROW_HOLD_CYC);
        if (!mode.row_hold) begin
            col_at = CW'(dmc_pkg::ROW_HOLD_CYC + 1);
        end
        if (mode.col_setup) begin
            cas_at = col_at + CW'(dmc_pkg::COL_SETUP_CYC);
        end else begin
            cas_at = col_at + CW'(dmc_pkg::COL_SETUP_SLOW);
        end
        if (wr && mode.write_delay && cas_at < CW'(dmc_pkg::WR_DLY_CYC)) begin
            cas_at = CW'(dmc_pkg::WR_DLY_CYC);
        end
        low_cnt = CW'(dmc_pkg::RAS_LOW_CYC) + extra;
        if (mode.row_timing == dmc_pkg::ROW_TIMING_2_2) begin
            pre_cnt = CW'(dmc_pkg::PRE_SHORT_CYC);
        end else begin
            pre_cnt = CW'(dmc_pkg::PRE_LONG_CYC);
        end
    end

    always_comb begin
        next_state        = state;
        next_owner        = owner;
        next_cnt          = cnt;
        next_extra        = extra;
        next_last_b       = last_b;
        next_wr           = wr;
        next_lane         = lane;
        next_col          = col;
        next_ras_n        = o_ras_n;
        next_cas_n        = o_cas_n;
        next_we_n         = o_we_n;
        next_addr         = o_addr;
        next_ready        = 2'h0;
        next_grant_b      = o_grant_b;
        next_refresh_busy = o_refresh_busy;
        next_ref_cnt      = ref_cnt;
        next_ref_pend     = ref_pend;
        is_ref            = (owner == dmc_pkg::OWN_REF);
        pick_b            = i_req[1] && (!i_req[0] || !last_b);
        bank              = pick_b ? i_bank_select_inputs[3:2] : i_bank_select_inputs[1:0];
        wcode             = i_burst[pick_b] ? mode.burst_wait : mode.wait_timing;

        if (tk.tick) begin
            if (ref_cnt >= 8'(REFRESH_TICKS - 1)) begin
                next_ref_cnt = '0;
            end else begin
                next_ref_cnt = ref_cnt + 1'b1;
            end
        end

        case (state)
            dmc_pkg::ST_IDLE: begin
                next_cnt = '0;
                if (ref_pend) begin
                    // refresh first; both ports keep waiting
                    next_owner        = dmc_pkg::OWN_REF;
                    next_ref_pend     = 1'b0;
                    next_extra        = '0;
                    next_ras_n        = ~dmc_pkg::RAS_ALL;
                    next_refresh_busy = 1'b1;
                    next_state        = dmc_pkg::ST_ROW;
                end else if (i_req != 2'h0) begin
                    next_owner   = pick_b ? dmc_pkg::OWN_B : dmc_pkg::OWN_A;
                    next_last_b  = pick_b;
                    next_grant_b = pick_b;
                    next_wr      = i_write_request_input[pick_b];
                    next_lane    = pick_b ? i_byte_lane[3:2] : i_byte_lane[1:0];
                    next_col     = pick_b ? i_col_addr[2*ADDR_W-1:ADDR_W]
                                          : i_col_addr[ADDR_W-1:0];
                    next_addr    = pick_b ? i_row_addr[2*ADDR_W-1:ADDR_W]
                                          : i_row_addr[ADDR_W-1:0];
                    // waits from mode bits, plus one host clock on wait insert
                    next_extra   = CW'((int'(wcode) + int'(!mode.wait_ext
                                   && !i_wait_insert_input)) * dmc_pkg::HOST_CYC);
                    if (mode.bank_cfg == dmc_pkg::BANK_CFG_QUAD) begin
                        next_ras_n = ~(dmc_pkg::RAS_ONE << bank);
                    end else if (bank[1]) begin
                        next_ras_n = ~dmc_pkg::RAS_HIGH_PAIR;
                    end else begin
                        next_ras_n = ~dmc_pkg::RAS_LOW_PAIR;
                    end
                    next_state = dmc_pkg::ST_ROW;
                end
            end
            dmc_pkg::ST_ROW: begin
                next_cnt = cnt + 1'b1;
                if (!is_ref) begin
                    next_we_n = ~wr;
                    if (cnt + 1'b1 == col_at) begin
                        next_addr = col;
                    end
                    if (cnt + 1'b1 == cas_at) begin
                        next_cas_n = ~lane;
                    end
                    // ready lands in the last row-strobe cycle
                    if (cnt == low_cnt - 2'h2) begin
                        next_ready = (owner == dmc_pkg::OWN_B) ? 2'h2 : 2'h1;
                    end
                end
                if (cnt == low_cnt - 1'b1) begin
                    next_ras_n = ~4'h0;
                    if (!mode.col_extend) begin
                        next_cas_n = ~2'h0;
                    end
                    next_we_n  = 1'b1;
                    next_cnt   = '0;
                    next_state = dmc_pkg::ST_PRE;
                end
            end
            dmc_pkg::ST_PRE: begin
                // no new access until precharge has run out
                next_cas_n        = ~2'h0;
                next_refresh_busy = 1'b0;
                next_cnt          = cnt + 1'b1;
                if (cnt == pre_cnt - 1'b1) begin
                    next_cnt   = '0;
                    next_state = dmc_pkg::ST_IDLE;
                end
            end
            default: begin
                next_state = dmc_pkg::ST_IDLE;
            end
        endcase

        // a new interval wins over the take of the previous one
        if (tk.tick && ref_cnt >= 8'(REFRESH_TICKS - 1)) begin
            next_ref_pend = 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            mode           <= dmc_pkg::MODE_RST;
            state          <= dmc_pkg::ST_IDLE;
            owner          <= dmc_pkg::OWN_A;
            cnt            <= '0;
            extra          <= '0;
            ref_cnt        <= '0;
            ref_pend       <= 1'b0;
            last_b         <= 1'b0;
            wr             <= 1'b0;
            lane           <= 2'h0;
            col            <= '0;
            o_ras_n        <= ~4'h0;
            o_cas_n        <= ~2'h0;
            o_we_n         <= 1'b1;
            o_addr         <= '0;
            o_ready        <= 2'h0;
            o_grant_b      <= 1'b0;
            o_refresh_busy <= 1'b0;
        end else begin
            mode           <= next_mode;
            state          <= next_state;
            owner          <= next_owner;
            cnt            <= next_cnt;
            extra          <= next_extra;
            ref_cnt        <= next_ref_cnt;
            ref_pend       <= next_ref_pend;
            last_b         <= next_last_b;
            wr             <= next_wr;
            lane           <= next_lane;
            col            <= next_col;
            o_ras_n        <= next_ras_n;
            o_cas_n        <= next_cas_n;
            o_we_n         <= next_we_n;
            o_addr         <= next_addr;
            o_ready        <= next_ready;
            o_grant_b      <= next_grant_b;
            o_refresh_busy <= next_refresh_busy;
        end
    end
endmodule

//--- rtl/dmc_pkg.sv
// constants, mode layout and state encodings for the memory controller
package dmc_pkg;

    // ==========================================================
    // clock and timing
    localparam int SYS_CLK_NS      = 50;
    localparam int HOST_CLK_NS     = 100;
    localparam int HOST_CYC        = HOST_CLK_NS / SYS_CLK_NS;
    localparam int RAS_LOW_HOST    = 2;
    localparam int RAS_LOW_CYC     = RAS_LOW_HOST * HOST_CYC;
    localparam int PRE_SHORT_HOST  = 2;
    localparam int PRE_LONG_HOST   = 3;
    localparam int PRE_SHORT_CYC   = PRE_SHORT_HOST * HOST_CYC;
    localparam int PRE_LONG_CYC    = PRE_LONG_HOST * HOST_CYC;
    localparam int ROW_HOLD_NS     = 15;
    localparam int ROW_HOLD_CYC    = (ROW_HOLD_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
    localparam int COL_SETUP_NS    = 0;
    localparam int COL_SETUP_CYC   = (COL_SETUP_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
    localparam int COL_SETUP_SLOW  = 1;
    localparam int WR_DLY_CYC      = HOST_CYC;
    localparam int READ_MAX_NS     = 200;
    localparam int READ_MAX_CYC    = READ_MAX_NS / SYS_CLK_NS;
    localparam int CNT_W           = 4;

    // ==========================================================
    // delay-line divider and refresh
    localparam int          DIV_W          = 3;
    localparam int          DIV_CODE0_RATIO = 10;
    localparam int          DIV_CNT_W      = 4;
    localparam int          REFRESH_TICKS  = 30;

    // ==========================================================
    // mode codes
    localparam logic [1:0]  ROW_TIMING_2_2 = 2'h2;
    localparam logic [2:0]  BANK_CFG_QUAD  = 3'h6;
    localparam logic [3:0]  RAS_ALL        = 4'hF;
    localparam logic [3:0]  RAS_LOW_PAIR   = 4'h3;
    localparam logic [3:0]  RAS_HIGH_PAIR  = 4'hC;
    localparam logic [3:0]  RAS_ONE        = 4'h1;

    typedef struct packed {
        logic [1:0] row_timing;    // {high, low}
        logic [1:0] wait_timing;   // {b, a}
        logic [1:0] burst_wait;    // {b, a}
        logic       wait_ext;
        logic [2:0] div_sel;
        logic [2:0] bank_cfg;      // {c, b, a}
        logic       col_setup;
        logic       row_hold;
        logic       write_delay;
        logic       col_extend;
    } dmc_mode_t;

    localparam dmc_mode_t MODE_RST = '{
        row_timing: 2'h2, wait_timing: 2'h0, burst_wait: 2'h0, wait_ext: 1'h0,
        div_sel: 3'h5, bank_cfg: 3'h6, col_setup: 1'h1, row_hold: 1'h1,
        write_delay: 1'h1, col_extend: 1'h0};

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_ROW  = 3'h2,
        ST_PRE  = 3'h4
    } dmc_state_t;

    typedef enum logic [2:0] {
        OWN_A   = 3'h1,
        OWN_B   = 3'h2,
        OWN_REF = 3'h4
    } dmc_owner_t;

endpackage

//--- rtl/dmc_tick_div.sv
// divides the synchronised delay-line clock down to the refresh tick
`timescale 1ns/100ps
module dmc_tick_div (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst,
    input  wire logic        i_delay_line_clock_input,
    dmc_tick_if.gen          tk
);
    // ==========================================================
    // synchroniser and edge detect
    logic                           sync_1;
    logic                           sync_2;
    logic                           sync_3;
    logic [dmc_pkg::DIV_CNT_W-1:0]  cnt;
    logic [dmc_pkg::DIV_CNT_W-1:0]  next_cnt;
    logic                           tick;
    logic                           next_tick;
    logic [dmc_pkg::DIV_CNT_W-1:0]  ratio;

    // ==========================================================
    // divider
    always_comb begin
        if (tk.div_sel == '0) begin
            ratio = dmc_pkg::DIV_CNT_W'(dmc_pkg::DIV_CODE0_RATIO);
        end else begin
            ratio = {1'b0, tk.div_sel};
        end
        next_cnt  = cnt;
        next_tick = 1'b0;
        if (sync_2 && !sync_3) begin
            if (cnt >= ratio - 1'b1) begin
                next_cnt  = '0;
                next_tick = 1'b1;
            end else begin
                next_cnt = cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            sync_1 <= 1'b0;
            sync_2 <= 1'b0;
            sync_3 <= 1'b0;
            cnt    <= '0;
            tick   <= 1'b0;
        end else begin
            sync_1 <= i_delay_line_clock_input;
            sync_2 <= sync_1;
            sync_3 <= sync_2;
            cnt    <= next_cnt;
            tick   <= next_tick;
        end
    end

    assign tk.tick = tick;
endmodule

//--- rtl/dmc_tick_if.sv
// link between the controller and its delay-line divider
`timescale 1ns/100ps
interface dmc_tick_if;
    logic [dmc_pkg::DIV_W-1:0] div_sel;
    logic                      tick;

    modport gen (input div_sel, output tick);
    modport use_tick (output div_sel, input tick);
endinterface

//--- test/dmc_ctrl_host_config_test.sv
// self-checking bench for the memory controller
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin n_errors++; \
    $display("mismatch %s expected %0h seen %0h", nm, ex, got); end end
module dmc_ctrl_host_config_test;
    localparam int          AW = 10;
    // default modes; divider 101 turns a 10 MHz delay clock into 2 MHz
    localparam logic [16:0] MD = 17'h0FA82;
    logic i_clk_sys, i_rst, dclk, dclk_en, prog, wins, we_n, grant_b, rbusy;
    logic [16:0]   m;
    logic [1:0]    go, wr, ube_n, req, burst, cas_n, ready;
    logic [3:0]    bank, lane, ras_n;
    logic [5:0]    addr;
    logic [15:0]   lat, cnt;
    logic [2*AW-1:0] row, col;
    logic [AW-1:0] maddr;
    int            n_errors, samples_checked;

    dmc_ctrl #(.ADDR_W(AW), .REFRESH_TICKS(2)) dmc_ctrl_i (
        .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_delay_line_clock_input(dclk), .i_prog(prog),
        .i_row_timing_bit_low(m[0]), .i_row_timing_bit_high(m[1]),
        .i_wait_timing_bit_a(m[2]), .i_wait_timing_bit_b(m[3]),
        .i_burst_wait_bit_a(m[4]), .i_burst_wait_bit_b(m[5]),
        .i_wait_extension_bit(m[6]), .i_div_sel(m[9:7]), .i_bank_config_bit_a(m[10]),
        .i_bank_config_bit_b(m[11]), .i_bank_config_bit_c(m[12]), .i_column_setup_bit(m[13]),
        .i_row_hold_bit(m[14]), .i_write_delay_bit(m[15]), .i_column_extend_control(m[16]),
        .i_wait_insert_input(wins), .i_req(req), .i_write_request_input(wr), .i_burst(burst),
        .i_bank_select_inputs(bank), .i_byte_lane(lane), .i_row_addr(row), .i_col_addr(col),
        .o_ras_n(ras_n), .o_cas_n(cas_n), .o_we_n(we_n), .o_addr(maddr), .o_ready(ready),
        .o_grant_b(grant_b), .o_refresh_busy(rbusy));
    dmc_host_model dmc_host_model_i [1:0] (.i_clk_sys(i_clk_sys), .i_go(go), .i_ready(ready),
        .i_byte_addr(addr), .i_upper_byte_enable_n(ube_n), .o_req(req), .o_bank(bank),
        .o_lane(lane), .o_lat(lat), .o_cnt(cnt));

    initial begin
        i_clk_sys = 1'b0;
        forever #25 i_clk_sys = ~i_clk_sys;
    end
    initial begin
        dclk = 1'b0;
        #7;
        forever #50 if (dclk_en) dclk = ~dclk;
    end

    // ==========================================================
    // shared tasks
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask
    task automatic wrap_up;
        if (n_errors == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic wait_cnt(input int p, input logic [7:0] n);
        int k;
        for (k = 0; k < 300 && cnt[8*p +: 8] !== n; k++) tick(1);
        if (cnt[8*p +: 8] !== n) begin
            n_errors++;
            wrap_up();
        end
    endtask
    task automatic shot(input int p, input int pre);
        logic [7:0] c;
        tick(pre);
        c = cnt[8*p +: 8];
        go[p] = 1'b1;
        tick(1);
        go[p] = 1'b0;
        wait_cnt(p, c + 8'h01);
    endtask

    // ==========================================================
    // scenarios
    task automatic t_banks;
        logic [1:0] ln;
        logic [2:0] a;
        for (int i = 0; i < 4; i++) begin
            a = {i[1:0], 1'b0};
            ln = {!i[0], 1'b1};
            addr[2:0] = a;
            ube_n[0] = i[0];
            wr[0] = i[1];
            row[AW-1:0] = {7'h00, a} ^ 10'h2A5;
            col[AW-1:0] = ~row[AW-1:0];
            tick(6);
            go[0] = 1'b1;
            for (int k = 0; k < 40 && ras_n === 4'hF; k++) tick(1);
            go[0] = 1'b0;
            `CHK("ras_n", ~(4'h1 << a[2:1]), ras_n)
            `CHK("row addr", row[AW-1:0], maddr)
            tick(1);
            `CHK("col addr", col[AW-1:0], maddr)
            `CHK("cas_n early", i[1] ? 2'h3 : ~ln, cas_n)
            tick(1);
            `CHK("cas_n", ~ln, cas_n)
            `CHK("we_n", !i[1], we_n)
            wait_cnt(0, cnt[7:0] + 8'h01);
            `CHK("latency", 8'(dmc_pkg::RAS_LOW_CYC + 1), lat[7:0])
        end
    endtask
    task automatic t_back_to_back;
        tick(6);
        go[0] = 1'b1;
        wait_cnt(0, cnt[7:0] + 8'h01);
        `CHK("first latency", 8'(dmc_pkg::RAS_LOW_CYC + 1), lat[7:0])
        wait_cnt(0, cnt[7:0] + 8'h01);
        go[0] = 1'b0;
        `CHK("precharge wait", 8'(dmc_pkg::PRE_SHORT_CYC + dmc_pkg::RAS_LOW_CYC), lat[7:0])
    endtask
    task automatic t_arbitrate;
        logic [7:0] ca, cb, la, lb;
        tick(6);
        ca = cnt[7:0];
        cb = cnt[15:8];
        go = 2'h3;
        tick(1);
        go = 2'h0;
        wait_cnt(0, ca + 8'h01);
        wait_cnt(1, cb + 8'h01);
        la = lat[7:0];
        lb = lat[15:8];
        `CHK("winner", 8'(dmc_pkg::RAS_LOW_CYC + 1), (la < lb) ? la : lb)
        `CHK("loser", 8'(2 * dmc_pkg::RAS_LOW_CYC + dmc_pkg::PRE_SHORT_CYC + 2), (la < lb) ? lb : la)
        `CHK("grant_b", lb > la, grant_b)
    endtask
    task automatic t_wait_insert;
        // mode inputs moved without programming must be ignored
        m = ~MD;
        wins = 1'b0;
        shot(0, 6);
        `CHK("wait latency", 8'(dmc_pkg::RAS_LOW_CYC + 1 + dmc_pkg::HOST_CYC), lat[7:0])
        m = MD;
        wins = 1'b1;
    endtask
    task automatic t_long_pre;
        // three-clock precharge; a burst access drops the programmed waits
        m = MD | 17'h0000D;
        burst[0] = 1'b1;
        prog = 1'b1;
        tick(1);
        prog = 1'b0;
        go[0] = 1'b1;
        wait_cnt(0, cnt[7:0] + 8'h01);
        wait_cnt(0, cnt[7:0] + 8'h01);
        go[0] = 1'b0;
        `CHK("long pre", 8'(dmc_pkg::PRE_LONG_CYC + dmc_pkg::RAS_LOW_CYC), lat[7:0])
    endtask
    task automatic t_refresh;
        dclk_en = 1'b1;
        for (int k = 0; k < 400 && rbusy !== 1'b1; k++) tick(1);
        `CHK("refresh ras_n", 4'h0, ras_n)
        shot(0, 1);
        `CHK("held off", 1'b1, lat[7:0] > 8'(dmc_pkg::RAS_LOW_CYC + 1))
        dclk_en = 1'b0;
    endtask

    initial begin
        n_errors = 0;
        samples_checked = 0;
        {i_rst, prog, wins, dclk_en} = 4'hA;
        m = MD;
        {go, wr, burst, ube_n} = 8'h00;
        addr = 6'h00;
        row = '0;
        col = '0;
        tick(4);
        i_rst = 1'b0;
        prog = 1'b1;
        tick(1);
        prog = 1'b0;
        t_banks();
        t_back_to_back();
        t_arbitrate();
        t_wait_insert();
        t_long_pre();
        t_refresh();
        wrap_up();
    end
endmodule

//--- test/dmc_ctrl_sva.sv
// concurrent checks on the memory controller ports
`timescale 1ns/100ps
module dmc_ctrl_sva (
    input wire logic       i_clk_sys,
    input wire logic       i_rst,
    input wire logic       i_wait_insert_input,
    input wire logic [3:0] o_ras_n,
    input wire logic [1:0] o_cas_n,
    input wire logic       o_we_n,
    input wire logic [1:0] o_ready,
    input wire logic       o_refresh_busy
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    logic [3:0] prev_ras;
    logic       ras_fall;

    always_ff @(posedge i_clk_sys) begin
        prev_ras <= i_rst ? 4'hF : o_ras_n;
    end
    assign ras_fall = (o_ras_n != 4'hF) && (prev_ras == 4'hF);

    // ==========================================================
    // row strobe timing
    a_ras_width: assert property (ras_fall |-> (o_ras_n != 4'hF) [*4])
        else $error("row strobe low too short");
    a_precharge_gap: assert property ((o_ras_n == 4'hF) && (prev_ras != 4'hF) |->
        (o_ras_n == 4'hF) [*4]) else $error("precharge too short");
    a_one_bank: assert property (o_ras_n != 4'hF && !o_refresh_busy |-> $onehot(~o_ras_n))
        else $error("more than one row strobe low");
    a_refresh_rows: assert property (o_refresh_busy && o_ras_n != 4'hF |->
        o_ras_n == 4'h0 && o_cas_n == 2'h3) else $error("bad refresh strobes");

    // ==========================================================
    // ready and column strobe
    a_zero_wait: assert property (ras_fall && !o_refresh_busy && $past(i_wait_insert_input)
        |-> (o_ready == 2'h0) [*3] ##1 (o_ready != 2'h0)) else $error("zero-wait ready off");
    a_wait_insert: assert property (ras_fall && !o_refresh_busy && !$past(i_wait_insert_input)
        |-> (o_ready == 2'h0) [*5] ##1 (o_ready != 2'h0)) else $error("inserted wait off");
    a_ready_owner: assert property (o_ready != 2'h0 |->
        $onehot(o_ready) && o_ras_n != 4'hF && !o_refresh_busy) else $error("ready misplaced");
    a_cas_ends: assert property (o_ras_n == 4'hF |-> o_cas_n == 2'h3)
        else $error("column strobe past row strobe");
    a_write_cas: assert property (ras_fall ##1 !o_we_n |-> o_cas_n == 2'h3 ##1 o_cas_n != 2'h3)
        else $error("write column strobe not delayed");
endmodule

bind dmc_ctrl dmc_ctrl_sva dmc_ctrl_sva_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_wait_insert_input(i_wait_insert_input), .o_ras_n(o_ras_n), .o_cas_n(o_cas_n),
    .o_we_n(o_we_n), .o_ready(o_ready), .o_refresh_busy(o_refresh_busy));

//--- test/dmc_host_model.sv
// host port model: holds a request until ready, forms bank and byte lanes
`timescale 1ns/100ps
module dmc_host_model (
    input  wire logic       i_clk_sys,
    input  wire logic       i_go,
    input  wire logic       i_ready,
    input  wire logic [2:0] i_byte_addr,
    input  wire logic       i_upper_byte_enable_n,
    output logic            o_req,
    output logic [1:0]      o_bank,
    output logic [1:0]      o_lane,
    output logic [7:0]      o_lat,
    output logic [7:0]      o_cnt
);
    assign o_bank = i_byte_addr[2:1];
    assign o_lane = {!i_upper_byte_enable_n, !i_byte_addr[0]};
    initial begin
        o_req = 1'b0;
        o_lat = 8'h00;
        o_cnt = 8'h00;
    end
    // request released only at the edge that samples ready
    always @(posedge i_clk_sys) begin
        if (o_req) begin
            o_lat <= o_lat + 8'h01;
            if (i_ready) begin
                o_req <= 1'b0;
                o_cnt <= o_cnt + 8'h01;
            end
        end else if (i_go) begin
            o_req <= 1'b1;
            o_lat <= 8'h00;
        end
    end
endmodule
